/* File: logic/wtaom_consts.vh */
// Constants for the weight to analog output mapper
`ifndef WTAOM_CONSTS_VH
`define WTAOM_CONSTS_VH

// Register byte offsets
`define WTAOM_ADDR_CTRL      8'h00
`define WTAOM_ADDR_LOW_LIM   8'h04
`define WTAOM_ADDR_HIGH_LIM  8'h08
`define WTAOM_ADDR_TRIM      8'h0c
`define WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL  8'h10
`define WTAOM_ADDR_STATUS    8'h14

// Control register fields
`define WTAOM_CTRL_IDX_LSB   0
`define WTAOM_CTRL_IDX_MSB   5
`define WTAOM_CTRL_NET_BIT   6
`define WTAOM_CTRL_OFS_BIT   7
`define WTAOM_CTRL_ERR_LSB   8
`define WTAOM_CTRL_ERR_MSB   9

// Limit register fields
`define WTAOM_LIM_MAG_MSB    23
`define WTAOM_LIM_NEG_BIT    31

// Error response encodings
`define WTAOM_ERR_FULL       2'h0
`define WTAOM_ERR_HOLD       2'h1
`define WTAOM_ERR_ZERO       2'h2

// Reset values
`define WTAOM_RST_IDX        6'h00
`define WTAOM_RST_ERR        2'h0
`define WTAOM_RST_LOW_MAG    24'h000000
`define WTAOM_RST_HIGH_MAG   24'h002710
`define WTAOM_RST_ZERO_TRIM  16'h0028
`define WTAOM_RST_SPAN_TRIM  16'he902

// Ranges
`define WTAOM_MAX_MAG        24'h98967f
`define WTAOM_NUM_SCALES     6'h20
`define WTAOM_OFS_DIVISOR    18'sh00005

// Timing
`define WTAOM_CLK_PERIOD_NS  10
`define WTAOM_UPDATE_NS      10000

`endif

/* File: logic/wtaom_divider.v */
// Sequential restoring divider for the weight mapping
`timescale 1ns/10ps
`default_nettype none

module wtaom_divider #(
  parameter [6:0] NW = 7'd41,
  parameter       DW = 25
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rstn,
  // Operands
  input  wire          start,
  input  wire [NW-1:0] numer,
  input  wire [DW-1:0] denom,
  // Result
  output reg           busy,
  output reg           done,
  output reg  [NW-1:0] quot
);

  reg  [DW-1:0] rem;
  reg  [6:0]    cnt;
  reg  [DW-1:0] den_q;
  wire [DW:0]   shifted = {rem, quot[NW-1]};
  wire [DW+1:0] trial   = {1'b0, shifted} - {2'b00, den_q};

  // One quotient bit per cycle; slow but small, updates are rare
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rem  <= {DW{1'b0}};
      quot <= {NW{1'b0}};
      cnt  <= 7'h00;
      den_q <= {DW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem  <= {DW{1'b0}};
        quot <= numer;
        den_q <= denom; // Held so a limit write mid-run cannot skew the quotient
        cnt  <= NW;
        busy <= 1'b1;
      end else if (busy) begin
        if (!trial[DW+1]) begin
          rem  <= trial[DW-1:0];
          quot <= {quot[NW-2:0], 1'b1};
        end else begin
          rem  <= shifted[DW-1:0];
          quot <= {quot[NW-2:0], 1'b0};
        end
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // wtaom_divider

`default_nettype wire

/* File: logic/wtaom_top.v */
// Weight to analog output mapper with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "wtaom_consts.vh"

// Summary of operation
// - Source is program value by default, or scale 1 to 32 by index.
// - A scale source tracks gross weight by default, or net weight.
// - Zero offset is 0 percent or 20 percent; 20 percent after reset.
// - System error drives full (default), holds, or drives the zero value.
// - Low limit magnitude 0 to 9999999, default 0, with negative flag.
// - High limit magnitude 0 to 9999999, default 10000, with negative flag.
// - Zero trim code 0 to 65535, default 40, sets the zero end code.
// - Span trim code 0 to 65535, default 59650, sets the full end code.
module wtaom_top #(
  parameter WW = 25,
  parameter UPDATE_CYCLES = `WTAOM_UPDATE_NS / `WTAOM_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rstn,
  // AHB-Lite slave
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire             hready,
  input  wire [31:0]      hwdata,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  // Weight sources, scale n at bits (n-1)*WW upward
  input  wire [32*WW-1:0] scale_gross_weight,
  input  wire [32*WW-1:0] scale_net_weight,
  input  wire             system_error,
  // Output stage
  output reg  [15:0]      dac_code,
  output reg              dac_load
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DIV  = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;
  localparam integer TICK_LAST_I = UPDATE_CYCLES - 1;
  localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];

  // Settings
  reg  [5:0]    scale_index_source;
  reg           weight_type_select;
  reg           offset_20pct;
  reg  [1:0]    error_response_select;
  reg  [23:0]   low_mag;
  reg           low_limit_negative;
  reg  [23:0]   high_mag;
  reg           high_limit_negative;
  reg  [15:0]   zero_trim_code;
  reg  [15:0]   span_trim_code;
  reg  [WW-1:0] program_controlled_source_weight;

  // Bus pipeline
  reg           wr_pend;
  reg           rd_pend;
  reg  [7:0]    addr_q;

  // Mapping state
  reg  [2:0]    state;
  reg  [15:0]   tick_cnt;
  reg           tick;
  reg  [15:0]   next_code;
  reg  [15:0]   base_code;
  reg           sub_flag;
  reg           clamp_low;
  reg           clamp_high;
  reg           err_seen;

  wire          div_busy;
  wire          div_done;
  wire [40:0]   div_quot;

  // Per-scale weight taps, chosen by gross or net setting
  wire [WW-1:0] scale_w [0:31];
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_scale
      assign scale_w[gi] = weight_type_select ? scale_net_weight[gi*WW +: WW]
                                              : scale_gross_weight[gi*WW +: WW];
    end
  endgenerate

  // Index 0 or out of range falls back to program control
  wire          use_program_controlled_source = (scale_index_source == 6'h00) ||
                           (scale_index_source > `WTAOM_NUM_SCALES);
  wire [4:0]    sel_idx  = scale_index_source[4:0] - 5'h01;
  wire [WW-1:0] tracked  = use_program_controlled_source ? program_controlled_source_weight : scale_w[sel_idx];

  // Signed limits
  wire signed [WW:0] low_s  = low_limit_negative ? -$signed({2'b00, low_mag})
                                                 : $signed({2'b00, low_mag});
  wire signed [WW:0] high_s = high_limit_negative ? -$signed({2'b00, high_mag})
                                                  : $signed({2'b00, high_mag});
  wire signed [WW:0] trk_s  = $signed({tracked[WW-1], tracked});
  wire signed [WW:0] span_w = high_s - low_s;
  wire signed [WW:0] pos_w  = trk_s - low_s;

  // Zero end code: trim alone, or trim plus a fifth of the code span
  wire signed [17:0] trim_diff = $signed({2'b00, span_trim_code}) -
                                 $signed({2'b00, zero_trim_code});
  wire signed [17:0] ofs_step  = trim_diff / `WTAOM_OFS_DIVISOR;
  wire [17:0]   lo_sum    = {2'b00, zero_trim_code} + ofs_step;
  wire [15:0]   code_lo   = offset_20pct ? lo_sum[15:0] : zero_trim_code;
  wire signed [17:0] code_diff = $signed({2'b00, span_trim_code}) -
                                 $signed({2'b00, code_lo});
  wire [17:0]   code_abs  = code_diff[17] ? -code_diff : code_diff;
  wire [40:0]   numer     = pos_w[WW-1:0] * code_abs[15:0];

  wire          map_low   = (span_w <= 0) || (pos_w <= 0);
  wire          map_high  = (trk_s >= high_s);

  // Divide starts on the tick edge itself; a weight that moves a cycle later cannot
  // push an out-of-range numerator into a run that the clamp test let through
  wire          div_go    = tick && (state == ST_IDLE) && !system_error &&
                            !map_low && !map_high;

  // Sign-adjusted quotient
  wire [15:0]   div_res   = sub_flag ? base_code - div_quot[15:0]
                                     : base_code + div_quot[15:0];

  wire          addr_ok   = hsel && htrans[1] && hready;

  // Register read view
  reg  [31:0]   rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `WTAOM_ADDR_CTRL: begin
        rd_mux[`WTAOM_CTRL_IDX_MSB:`WTAOM_CTRL_IDX_LSB] = scale_index_source;
        rd_mux[`WTAOM_CTRL_NET_BIT] = weight_type_select;
        rd_mux[`WTAOM_CTRL_OFS_BIT] = offset_20pct;
        rd_mux[`WTAOM_CTRL_ERR_MSB:`WTAOM_CTRL_ERR_LSB] = error_response_select;
      end
      `WTAOM_ADDR_LOW_LIM: begin
        rd_mux[`WTAOM_LIM_MAG_MSB:0] = low_mag;
        rd_mux[`WTAOM_LIM_NEG_BIT]   = low_limit_negative;
      end
      `WTAOM_ADDR_HIGH_LIM: begin
        rd_mux[`WTAOM_LIM_MAG_MSB:0] = high_mag;
        rd_mux[`WTAOM_LIM_NEG_BIT]   = high_limit_negative;
      end
      `WTAOM_ADDR_TRIM:     rd_mux = {span_trim_code, zero_trim_code};
      `WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL: rd_mux = {{(32-WW){program_controlled_source_weight[WW-1]}}, program_controlled_source_weight};
      `WTAOM_ADDR_STATUS:   rd_mux = {12'h000, err_seen, clamp_high, clamp_low,
                                      (state != ST_IDLE), dac_code};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // Bus phases: writes take no wait, reads take one wait to register data
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
      end else begin
        wr_pend <= addr_ok && hwrite;
        rd_pend <= addr_ok && !hwrite;
        if (addr_ok) begin
          addr_q <= (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hff;
        end
        if (addr_ok && !hwrite) begin
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Settings written in the data phase; oversized magnitudes saturate
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scale_index_source    <= `WTAOM_RST_IDX;
      weight_type_select    <= 1'b0;
      offset_20pct          <= 1'b1;
      error_response_select <= `WTAOM_RST_ERR;
      low_mag               <= `WTAOM_RST_LOW_MAG;
      low_limit_negative    <= 1'b0;
      high_mag              <= `WTAOM_RST_HIGH_MAG;
      high_limit_negative   <= 1'b0;
      zero_trim_code        <= `WTAOM_RST_ZERO_TRIM;
      span_trim_code        <= `WTAOM_RST_SPAN_TRIM;
      program_controlled_source_weight           <= {WW{1'b0}};
    end else if (wr_pend) begin
      case (addr_q)
        `WTAOM_ADDR_CTRL: begin
          scale_index_source    <= hwdata[`WTAOM_CTRL_IDX_MSB:`WTAOM_CTRL_IDX_LSB];
          weight_type_select    <= hwdata[`WTAOM_CTRL_NET_BIT];
          offset_20pct          <= hwdata[`WTAOM_CTRL_OFS_BIT];
          error_response_select <= hwdata[`WTAOM_CTRL_ERR_MSB:`WTAOM_CTRL_ERR_LSB];
        end
        `WTAOM_ADDR_LOW_LIM: begin
          low_mag <= (hwdata[23:0] > `WTAOM_MAX_MAG) ? `WTAOM_MAX_MAG
                                                     : hwdata[23:0];
          low_limit_negative <= hwdata[`WTAOM_LIM_NEG_BIT];
        end
        `WTAOM_ADDR_HIGH_LIM: begin
          high_mag <= (hwdata[23:0] > `WTAOM_MAX_MAG) ? `WTAOM_MAX_MAG
                                                      : hwdata[23:0];
          high_limit_negative <= hwdata[`WTAOM_LIM_NEG_BIT];
        end
        `WTAOM_ADDR_TRIM: begin
          zero_trim_code <= hwdata[15:0];
          span_trim_code <= hwdata[31:16];
        end
        `WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL: program_controlled_source_weight <= hwdata[WW-1:0];
        default: ;
      endcase
    end
  end

  // Update rate divider
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_LAST);
      if (tick_cnt == TICK_LAST) begin
        tick_cnt <= 16'h0000;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // Mapping sequence; error response outranks normal tracking
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      next_code  <= 16'h0000;
      base_code  <= 16'h0000;
      sub_flag   <= 1'b0;
      clamp_low  <= 1'b0;
      clamp_high <= 1'b0;
      err_seen   <= 1'b0;
      dac_code   <= 16'h0000;
      dac_load   <= 1'b0;
    end else begin
      dac_load  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (tick) begin
            err_seen   <= system_error;
            clamp_low  <= 1'b0;
            clamp_high <= 1'b0;
            state      <= ST_LOAD;
            if (system_error) begin
              case (error_response_select)
                `WTAOM_ERR_HOLD: next_code <= dac_code;
                `WTAOM_ERR_ZERO: next_code <= code_lo;
                default:         next_code <= span_trim_code;
              endcase
            end else if (map_low) begin
              next_code <= code_lo;
              clamp_low <= 1'b1;
            end else if (map_high) begin
              next_code  <= span_trim_code;
              clamp_high <= 1'b1;
            end else begin
              base_code <= code_lo;
              sub_flag  <= code_diff[17];
              state     <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (div_done) begin
            next_code <= div_res;
            state     <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          dac_code <= next_code;
          dac_load <= 1'b1;
          state    <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Quotient is below the code span, so its low 16 bits carry it all
  wtaom_divider #(
    .NW (7'd41),
    .DW (WW)
  ) u_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (div_go),
    .numer   (numer),
    .denom   (span_w[WW-1:0]),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

endmodule // wtaom_top

`default_nettype wire

/* File: verif/wtaom_dac_model.sv */
// Behavioural model of the analog output converter stage
`timescale 1ns/10ps
`default_nettype none

module wtaom_dac_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Code from the mapper
  input  wire logic [15:0] dac_code,
  input  wire logic        dac_load,
  // Level the stage drives
  output var  logic [15:0] level
);
  // Latch only on the load strobe; a code that moves without a strobe never reaches the pin
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      level <= 16'h0000;
    end else if (dac_load) begin
      level <= dac_code;
    end
  end
endmodule // wtaom_dac_model

`default_nettype wire

/* File: verif/wtaom_checker.sv */
// Concurrent checks on the mapper bus and output ports
`timescale 1ns/10ps
`default_nettype none

module wtaom_checker (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Bus
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Output stage
  input  wire logic        system_error,
  input  wire logic [15:0] dac_code,
  input  wire logic        dac_load
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] gap;
  // Cycles since the last load, saturating so a long hold never wraps
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) gap <= 16'h0000;
    else if (dac_load) gap <= 16'h0000;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("hresp not OKAY");
  property p_rd; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  property p_wr; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_idle; hsel && !htrans[1] && hreadyout |=> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("idle cycle stalled");
  property p_rdata; $changed(hrdata) |-> hreadyout && !$past(hreadyout); endproperty
  a_rdata: assert property (p_rdata) else $error("hrdata moved outside read");
  property p_pulse; dac_load |=> !dac_load; endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
  property p_code; $changed(dac_code) |-> ##[0:1] dac_load; endproperty
  a_code: assert property (p_code) else $error("code moved without load");
  property p_gap; dac_load |-> gap >= 16'd13; endproperty
  a_gap: assert property (p_gap) else $error("loads too close");
  c_rd: cover property (hsel && htrans[1] && !hwrite);
  c_err: cover property (system_error && dac_load);
  c_load: cover property (dac_load ##1 !dac_load);
endmodule // wtaom_checker

bind wtaom_top wtaom_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .system_error(system_error),
  .dac_code(dac_code), .dac_load(dac_load));

`default_nettype wire

/* File: verif/weight_to_analog_output_mapper_test.sv */
// Self-checking bench for the weight to analog output mapper
`timescale 1ns/10ps
`default_nettype none
`include "wtaom_consts.vh"

module weight_to_analog_output_mapper_test;
  logic ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, system_error = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'h0;
  logic [799:0] gw = 800'h0, nw = 800'h0;
  logic [15:0] dac_code, level, prev;
  logic hreadyout, hresp, dac_load;
  integer n_mismatch = 0, checks = 0, zt = 40, st = 59650, lo = 0, hi = 10000, ofs = 1, i, e;
  always #5 ref_clk = ~ref_clk;
  wtaom_top #(.UPDATE_CYCLES(64)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scale_gross_weight(gw), .scale_net_weight(nw), .system_error(system_error),
    .dac_code(dac_code), .dac_load(dac_load));
  wtaom_dac_model u_dac (.ref_clk(ref_clk), .rstn(rstn), .dac_code(dac_code),
    .dac_load(dac_load), .level(level));
  // Expected code from the present settings; longint keeps the product from overflowing
  function automatic [15:0] ec(input longint w);
    longint cl;
    cl = ofs ? zt + (st - zt) / 5 : zt;
    if (w <= lo || hi <= lo) ec = cl;
    else if (w >= hi) ec = st;
    else if (st < cl) ec = cl - (w - lo) * (cl - st) / (hi - lo);
    else ec = cl + (w - lo) * (st - cl) / (hi - lo);
  endfunction
  task end_sim;
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One AHB-Lite single transfer; waits on hready at each phase, never a fixed count
  task xfer(input [31:0] a, input w, input [31:0] wd);
    haddr <= a; htrans <= 2'h2; hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0; hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    d = hrdata;
  endtask
  task rdc(input [31:0] a, input [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk("register", d, exp);
  endtask
  // Two loads, so the second reflects settings made before the tick; a hold strobes too
  task upd(input [15:0] x);
    repeat (2) begin
      i = 0;
      @(posedge ref_clk);
      while (dac_load !== 1'b1 && i < 200) begin @(posedge ref_clk); i = i + 1; end
      chk("load within limit", {31'h0, i < 200}, 32'h1);
    end
    #1 chk("dac level", {16'h0, level}, {16'h0, x});
  endtask
  task setw(input integer n, input integer g, input integer nv);
    gw[(n - 1) * 25 +: 25] <= g[24:0];
    nw[(n - 1) * 25 +: 25] <= nv[24:0];
  endtask
  initial begin
    #500000 n_mismatch = n_mismatch + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdc(`WTAOM_ADDR_CTRL, 32'h00000080);
    rdc(`WTAOM_ADDR_LOW_LIM, 32'h0);
    rdc(`WTAOM_ADDR_HIGH_LIM, 32'h00002710);
    rdc(`WTAOM_ADDR_TRIM, 32'he9020028);
    rdc(32'h18, 32'h0);
    upd(ec(0));
    xfer(`WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL, 1'b1, 32'd5000);
    upd(ec(5000));
    xfer(`WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL, 1'b1, 32'd20000);
    upd(ec(20000));
    ofs = 0; zt = 1000; st = 50000;
    xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h0);
    xfer(`WTAOM_ADDR_TRIM, 1'b1, {16'd50000, 16'd1000});
    xfer(`WTAOM_ADDR_PROGRAM_CONTROLLED_SOURCE_VAL, 1'b1, 32'd5000);
    upd(ec(5000));
    setw(1, 2500, 7500);
    xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h01);
    upd(ec(2500));
    xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h41);
    upd(ec(7500));
    setw(32, -3000, 0);
    lo = -5000;
    xfer(`WTAOM_ADDR_LOW_LIM, 1'b1, 32'h80001388);
    rdc(`WTAOM_ADDR_LOW_LIM, 32'h80001388);
    xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h20);
    upd(ec(-3000));
    hi = -1000;
    xfer(`WTAOM_ADDR_HIGH_LIM, 1'b1, 32'h800003e8);
    upd(ec(-3000));
    prev = ec(-3000);
    // Hold is selected before the error rises, so no full-scale update can slip in
    xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h00000120);
    system_error <= 1'b1;
    // Hold first, so the held value is known; then full and zero actions
    for (e = 0; e < 3; e = e + 1) begin
      xfer(`WTAOM_ADDR_CTRL, 1'b1, 32'h20 | ((e == 0 ? 1 : e == 1 ? 0 : 2) << 8));
      upd(e == 0 ? prev : e == 1 ? st[15:0] : zt[15:0]);
    end
    end_sim;
  end
endmodule // weight_to_analog_output_mapper_test

`default_nettype wire
